// File: hdl/vfc_control.sv
// Control register set of a telephone voice front end, with its PCM byte path.
// Assumes serial control and PCM pins are synchronous to clk_i and slow against it.
`timescale 1ns/1ps
module vfc_control (
  input wire logic clk_i,
  input wire logic resetn_i,
  // Serial control link.
  input wire logic cs_n_i,
  input wire logic cclk_i,
  input wire logic ci_i,
  output logic co_o,
  output logic co_oe_n_o,
  // PCM link.
  input wire logic gci_mode_i,
  input wire logic fs_i,
  input wire logic bclk_i,
  input wire logic dr_i,
  output logic dx_o,
  output logic dx_oe_n_o,
  // Encoder byte and decoder stream.
  input wire logic [7:0] tx_enc_data_i,
  output logic [7:0] rx_dec_data_o,
  output logic rx_dec_valid_o,
  input wire logic rx_dec_ready_i,
  output logic rx_dec_drop_o,
  // Analog steering.
  output logic mic_choice_o,
  output logic tx_input_on_o,
  output logic sidetone_on_o,
  output logic aux_to_speaker_amp_o,
  output logic tonegen_to_loudspeaker_o,
  output logic tonegen_to_earpiece_o,
  output logic speech_to_loudspeaker_o,
  output logic speech_to_earpiece_o,
  output logic tonegen_to_tx_path_o,
  output logic [3:0] tx_gain_db_o,
  output logic [3:0] sidetone_att_code_o,
  output logic [3:0] earpiece_att_db_o,
  output logic [4:0] speaker_att_db_o,
  // Tone generator.
  output logic wave_shape_o,
  output logic [1:0] tone_square_o,
  output logic [15:0] tone_phase_o,
  output logic [4:0] tone_a_att_db_o,
  output logic [4:0] tone_b_att_db_o
);

  typedef enum logic [1:0] {
    VFC_SER_IDLE,
    VFC_SER_CMD,
    VFC_SER_DATA,
    VFC_SER_DONE
  } vfc_ser_t;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release.

  logic [1:0] rst_sync;
  wire rst_n;

  // Assert at once, release after two clean edges.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Serial control link: instruction byte then data byte.

  vfc_ser_t ser_state;
  vfc_ser_t next_ser_state;
  logic cclk_q;
  logic [2:0] ser_bits;
  logic [7:0] ser_in;
  logic [7:0] ser_out;
  logic [3:0] cmd_idx;
  logic cmd_read;
  logic [7:0] cfg [vfc_pkg::REG_LAST+1];
  logic [7:0] rx_capture;
  wire cclk_rise;
  wire cclk_fall;
  wire byte_done;
  wire [7:0] shifted_in;
  wire cmd_is_read;
  wire wr_commit;
  wire idx_mapped;
  wire [3:0] rd_idx;
  wire rd_mapped;
  wire [7:0] rd_data;

  assign cclk_rise = cclk_i & ~cclk_q & ~cs_n_i;
  assign cclk_fall = ~cclk_i & cclk_q & ~cs_n_i;
  assign byte_done = cclk_rise & (ser_bits == 3'h7);
  assign shifted_in = {ser_in[6:0], ci_i};
  assign cmd_is_read = shifted_in[vfc_pkg::CMD_READ_BIT];
  assign idx_mapped = (cmd_idx >= 4'(vfc_pkg::REG_FIRST))
                    & (cmd_idx <= 4'(vfc_pkg::REG_LAST));
  // The read index is the byte arriving now; cmd_idx still holds the previous one.
  assign rd_idx = shifted_in[7:4];
  assign rd_mapped = (rd_idx >= 4'(vfc_pkg::REG_FIRST)) & (rd_idx <= 4'(vfc_pkg::REG_LAST));
  // Only the second byte's last edge commits a write.
  assign wr_commit = byte_done & (ser_state == VFC_SER_DATA) & ~cmd_read & idx_mapped;

  // Received data reads the captured byte; the transmit override is write only.
  assign rd_data = (rd_idx == vfc_pkg::REG_RX_DATA) ? rx_capture :
                   (rd_idx == vfc_pkg::REG_TX_DATA) ? 8'h00 :
                   rd_mapped ? cfg[rd_idx] : 8'h00;

  // Raising chip select aborts any half-sent instruction.
  always_comb begin
    next_ser_state = ser_state;
    case (ser_state)
      VFC_SER_IDLE: next_ser_state = cs_n_i ? VFC_SER_IDLE : VFC_SER_CMD;
      VFC_SER_CMD: begin
        if (cs_n_i) begin
          next_ser_state = VFC_SER_IDLE;
        end else if (byte_done) begin
          next_ser_state = VFC_SER_DATA;
        end
      end
      VFC_SER_DATA: begin
        if (cs_n_i) begin
          next_ser_state = VFC_SER_IDLE;
        end else if (byte_done) begin
          next_ser_state = VFC_SER_DONE;
        end
      end
      VFC_SER_DONE: next_ser_state = cs_n_i ? VFC_SER_IDLE : VFC_SER_DONE;
      default: next_ser_state = VFC_SER_IDLE;
    endcase
  end

  // Input sampled on rising clock edges; read data leaves on falling edges.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ser_state <= VFC_SER_IDLE;
      cclk_q <= 1'b0;
      ser_bits <= 3'h0;
      ser_in <= 8'h00;
      ser_out <= 8'h00;
      cmd_idx <= 4'h0;
      cmd_read <= 1'b0;
      co_o <= 1'b0;
      co_oe_n_o <= 1'b1;
    end else begin
      ser_state <= next_ser_state;
      cclk_q <= cclk_i;
      ser_bits <= (cs_n_i || ser_state == VFC_SER_IDLE) ? 3'h0 :
                  cclk_rise ? ser_bits + 3'h1 : ser_bits;
      ser_in <= cclk_rise ? shifted_in : ser_in;
      if (byte_done && ser_state == VFC_SER_CMD) begin
        cmd_idx <= shifted_in[7:4];
        cmd_read <= cmd_is_read;
      end
      if (byte_done && ser_state == VFC_SER_CMD) begin
        ser_out <= rd_data;
      end else if (cclk_fall && ser_state == VFC_SER_DATA && cmd_read) begin
        ser_out <= {ser_out[6:0], 1'b0};
      end
      if (cclk_fall && ser_state == VFC_SER_DATA && cmd_read) begin
        co_o <= ser_out[7];
      end
      // Released once chip select rises or the last data bit was clocked.
      co_oe_n_o <= cs_n_i ? 1'b1 :
                   (cclk_fall && ser_state == VFC_SER_DATA && cmd_read) ? 1'b0 :
                   (ser_state != VFC_SER_DATA) ? 1'b1 : co_oe_n_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage, one byte per index.

  // Frequency codes are stored as plain unsigned bytes, msb at bit 7.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i <= vfc_pkg::REG_LAST; i++) begin
        cfg[i] <= vfc_pkg::REG_RESET;
      end
    end else if (wr_commit) begin
      cfg[cmd_idx] <= shifted_in;
    end
  end

  wire [7:0] path_cfg = cfg[vfc_pkg::REG_PATH];
  wire [7:0] route_cfg = cfg[vfc_pkg::REG_ROUTE];
  wire [7:0] txg_cfg = cfg[vfc_pkg::REG_TX_GAIN];
  wire [7:0] rxg_cfg = cfg[vfc_pkg::REG_RX_GAIN];
  wire [7:0] tone_cfg = cfg[vfc_pkg::REG_TONE];
  wire voice_on = path_cfg[vfc_pkg::VOICE_ENABLE];

  ////////////////////////////////////////////////////////////////////////////
  // PCM slot timing, capture and transmit.

  logic bclk_q;
  logic [5:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic push_valid;
  logic [7:0] push_data;
  wire bclk_rise;
  wire bclk_fall;
  wire [1:0] slot_sel;
  wire [5:0] slot_start;
  wire in_slot;
  wire last_bit;
  wire [7:0] tx_src;
  wire [7:0] rx_src;
  wire [7:0] rx_next_shift;
  wire [5:0] cnt_next;
  wire tx_slot;
  wire [7:0] tx_word;

  assign bclk_rise = bclk_i & ~bclk_q;
  assign bclk_fall = ~bclk_i & bclk_q;
  // Four slots in GCI mode, otherwise only the low bit picks slot one or two.
  assign slot_sel = gci_mode_i ?
    {path_cfg[vfc_pkg::CHANNEL_PICK_HIGH], path_cfg[vfc_pkg::CHANNEL_PICK_LOW]} :
    {1'b0, path_cfg[vfc_pkg::CHANNEL_PICK_LOW]};
  assign slot_start = 6'({slot_sel, 3'h0});
  assign in_slot = (bit_cnt >= slot_start) && (bit_cnt < slot_start + 6'(vfc_pkg::SLOT_BITS));
  assign last_bit = (bit_cnt == slot_start + 6'(vfc_pkg::SLOT_BITS - 1));
  assign tx_src = path_cfg[vfc_pkg::TX_PIN_HOST_SUBSTITUTE] ?
                  cfg[vfc_pkg::REG_TX_DATA] : tx_enc_data_i;
  assign rx_next_shift = {rx_shift[6:0], dr_i};
  assign rx_src = path_cfg[vfc_pkg::RX_PATH_HOST_INJECT] ?
                  cfg[vfc_pkg::REG_RX_DATA] : rx_next_shift;
  // Transmit looks at the count this rise moves to, so slot bit k leaves at start+k.
  assign cnt_next = fs_i ? 6'h00 :
                    (bit_cnt == vfc_pkg::BIT_CNT_MAX) ? bit_cnt : bit_cnt + 6'h1;
  assign tx_slot = (cnt_next >= slot_start) && (cnt_next < slot_start + 6'(vfc_pkg::SLOT_BITS));
  assign tx_word = fs_i ? tx_src : tx_shift;

  // Bit count restarts at frame sync and holds at BIT_CNT_MAX (63).
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bclk_q <= 1'b0;
      bit_cnt <= vfc_pkg::BIT_CNT_MAX;
      tx_shift <= 8'h00;
      dx_o <= 1'b0;
      dx_oe_n_o <= 1'b1;
    end else begin
      bclk_q <= bclk_i;
      if (bclk_rise) begin
        bit_cnt <= cnt_next;
        tx_shift <= tx_slot ? {tx_word[6:0], 1'b0} : tx_word;
        dx_o <= tx_slot & tx_word[7];
        dx_oe_n_o <= ~(tx_slot & voice_on);
      end
    end
  end

  // Slot bits are taken on falling edges; the frame's byte lands after the last.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift <= 8'h00;
      rx_capture <= 8'h00;
      push_valid <= 1'b0;
      push_data <= 8'h00;
    end else begin
      if (bclk_fall && in_slot) begin
        rx_shift <= rx_next_shift;
      end
      if (bclk_fall && last_bit) begin
        rx_capture <= rx_next_shift;
      end
      // A full FIFO refuses the frame rather than stalling the PCM clock.
      push_valid <= bclk_fall & last_bit & voice_on;
      push_data <= (bclk_fall && last_bit) ? rx_src : push_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoder stream through the FIFO.

  vfc_stream_if #(.WIDTH(vfc_pkg::FIFO_WIDTH)) dec_q ();
  wire take_word;

  assign dec_q.in_valid = push_valid;
  assign dec_q.in_data = push_data;
  assign take_word = dec_q.out_valid & (~rx_dec_valid_o | rx_dec_ready_i);
  assign dec_q.out_ready = take_word;

  vfc_fifo #(
    .WIDTH(vfc_pkg::FIFO_WIDTH),
    .DEPTH(vfc_pkg::FIFO_DEPTH)
  ) u_dec_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .port(dec_q.fifo)
  );

  // Output holding stage keeps the decoder port registered.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_dec_data_o <= 8'h00;
      rx_dec_valid_o <= 1'b0;
      rx_dec_drop_o <= 1'b0;
    end else begin
      rx_dec_valid_o <= take_word | (rx_dec_valid_o & ~rx_dec_ready_i);
      rx_dec_data_o <= take_word ? dec_q.out_data : rx_dec_data_o;
      rx_dec_drop_o <= push_valid & ~dec_q.in_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog steering and gain codes.

  wire [3:0] tone_code = tone_cfg[vfc_pkg::HI_NIB_MSB:vfc_pkg::HI_NIB_LSB];
  wire [4:0] tone_att;
  // Three dB steps to -21, then -24 and -27 at the top of the code range.
  assign tone_att = tone_code[3] ?
    (tone_code[0] ? vfc_pkg::TONE_ATT_MAX_DB : vfc_pkg::TONE_ATT_LOW_DB) :
    5'(tone_code[2:0] * vfc_pkg::TONE_STEP_DB);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mic_choice_o <= 1'b0;
      tx_input_on_o <= 1'b0;
      sidetone_on_o <= 1'b0;
      aux_to_speaker_amp_o <= 1'b0;
      tonegen_to_loudspeaker_o <= 1'b0;
      tonegen_to_earpiece_o <= 1'b0;
      speech_to_loudspeaker_o <= 1'b0;
      speech_to_earpiece_o <= 1'b0;
      tonegen_to_tx_path_o <= 1'b0;
      tx_gain_db_o <= 4'h0;
      sidetone_att_code_o <= 4'h0;
      earpiece_att_db_o <= 4'h0;
      speaker_att_db_o <= 5'h00;
      wave_shape_o <= 1'b0;
      tone_a_att_db_o <= 5'h00;
      tone_b_att_db_o <= 5'h00;
    end else begin
      mic_choice_o <= route_cfg[vfc_pkg::MIC_CHOICE];
      tx_input_on_o <= route_cfg[vfc_pkg::TX_INPUT_ON];
      sidetone_on_o <= route_cfg[vfc_pkg::SIDETONE_ON] & route_cfg[vfc_pkg::TX_INPUT_ON];
      aux_to_speaker_amp_o <= route_cfg[vfc_pkg::AUX_TO_SPEAKER_AMP];
      tonegen_to_loudspeaker_o <= route_cfg[vfc_pkg::TONEGEN_TO_LOUDSPEAKER];
      tonegen_to_earpiece_o <= route_cfg[vfc_pkg::TONEGEN_TO_EARPIECE];
      speech_to_loudspeaker_o <= route_cfg[vfc_pkg::SPEECH_TO_LOUDSPEAKER];
      speech_to_earpiece_o <= route_cfg[vfc_pkg::SPEECH_TO_EARPIECE];
      tonegen_to_tx_path_o <= tone_cfg[vfc_pkg::TONEGEN_TO_TX_PATH];
      tx_gain_db_o <= txg_cfg[vfc_pkg::HI_NIB_MSB:vfc_pkg::HI_NIB_LSB];
      sidetone_att_code_o <= txg_cfg[vfc_pkg::LO_NIB_MSB:vfc_pkg::LO_NIB_LSB];
      earpiece_att_db_o <= rxg_cfg[vfc_pkg::HI_NIB_MSB:vfc_pkg::HI_NIB_LSB];
      speaker_att_db_o <= {rxg_cfg[vfc_pkg::LO_NIB_MSB:vfc_pkg::LO_NIB_LSB], 1'b0};
      wave_shape_o <= tone_cfg[vfc_pkg::WAVE_SHAPE];
      tone_a_att_db_o <= tone_att;
      tone_b_att_db_o <= tone_att + vfc_pkg::TONE_B_OFFSET_DB;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tone generators: phase accumulators, a at index 0, b at index 1.

  // Bursts are not timed here; the host toggles the enables itself.
  for (genvar g = 0; g < 2; g++) begin : g_tone
    logic [31:0] phase;
    wire on = tone_cfg[g == 0 ? vfc_pkg::TONE_A_ON : vfc_pkg::TONE_B_ON];
    wire [7:0] code = cfg[g == 0 ? vfc_pkg::REG_FREQ_A : vfc_pkg::REG_FREQ_B];
    // Step is code times 2^32 / (0.128 * clock rate), truncated.
    wire [31:0] step = 32'(code * vfc_pkg::TONE_INC_K);
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        phase <= 32'h0000_0000;
      end else begin
        phase <= on ? phase + step : 32'h0000_0000;
      end
    end
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        tone_square_o[g] <= 1'b0;
        tone_phase_o[g*8 +: 8] <= 8'h00;
      end else begin
        tone_square_o[g] <= on & phase[31];
        tone_phase_o[g*8 +: 8] <= on ? phase[31:24] : 8'h00;
      end
    end
  end

endmodule // vfc_control

// File: hdl/vfc_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a synchronous, released reset from the parent.
`timescale 1ns/1ps
module vfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  vfc_stream_if.fifo port
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire do_push;
  wire do_pop;

  // Full and empty come straight from the occupancy count.
  assign port.in_ready = (count != DEPTH_W);
  assign port.out_valid = (count != '0);
  assign port.out_data = mem[rd_ptr];
  assign do_push = port.in_valid & port.in_ready;
  assign do_pop = port.out_valid & port.out_ready;

  // Storage is written only; no reset needed on the data words.
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= port.in_data;
    end
  end

  // Pointers wrap naturally since the depth is a power of two.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= do_push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= do_pop ? rd_ptr + 1'b1 : rd_ptr;
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule // vfc_fifo

// File: include/vfc_pkg.sv
// Constants shared by the voice front end control block and its FIFO.
// Assumes a 200 MHz system clock; all registers are eight bits wide, holding one-bit fields, nibble fields or whole-byte codes.
package vfc_pkg;

  // Register indices carried in the high nibble of the instruction byte.
  localparam logic [3:0] REG_PATH = 4'h1;
  localparam logic [3:0] REG_RX_DATA = 4'h2;
  localparam logic [3:0] REG_TX_DATA = 4'h3;
  localparam logic [3:0] REG_ROUTE = 4'h4;
  localparam logic [3:0] REG_TX_GAIN = 4'h5;
  localparam logic [3:0] REG_RX_GAIN = 4'h6;
  localparam logic [3:0] REG_TONE = 4'h7;
  localparam logic [3:0] REG_FREQ_A = 4'h8;
  localparam logic [3:0] REG_FREQ_B = 4'h9;
  localparam int REG_FIRST = 1;
  localparam int REG_LAST = 9;

  // Instruction byte: bit 2 set asks for a read.
  localparam int CMD_READ_BIT = 2;

  // Field positions in path_and_slot_control.
  localparam int RX_PATH_HOST_INJECT = 4;
  localparam int TX_PIN_HOST_SUBSTITUTE = 3;
  localparam int VOICE_ENABLE = 2;
  localparam int CHANNEL_PICK_HIGH = 1;
  localparam int CHANNEL_PICK_LOW = 0;

  // Field positions in audio_input_routing.
  localparam int MIC_CHOICE = 7;
  localparam int TX_INPUT_ON = 6;
  localparam int SIDETONE_ON = 5;
  localparam int AUX_TO_SPEAKER_AMP = 4;
  localparam int TONEGEN_TO_LOUDSPEAKER = 3;
  localparam int TONEGEN_TO_EARPIECE = 2;
  localparam int SPEECH_TO_LOUDSPEAKER = 1;
  localparam int SPEECH_TO_EARPIECE = 0;

  // Field positions in tone_generator_control.
  localparam int TONE_A_ON = 3;
  localparam int TONE_B_ON = 2;
  localparam int WAVE_SHAPE = 1;
  localparam int TONEGEN_TO_TX_PATH = 0;

  // Nibble fields: upper and lower halves of the gain registers.
  localparam int HI_NIB_MSB = 7;
  localparam int HI_NIB_LSB = 4;
  localparam int LO_NIB_MSB = 3;
  localparam int LO_NIB_LSB = 0;

  // Every register comes up cleared.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Tone attenuator steps in dB and the extra offset of generator b.
  localparam logic [4:0] TONE_STEP_DB = 5'h03;
  localparam logic [4:0] TONE_ATT_LOW_DB = 5'h18;
  localparam logic [4:0] TONE_ATT_MAX_DB = 5'h1B;
  localparam logic [4:0] TONE_B_OFFSET_DB = 5'h02;

  // Frequency = code / 0.128 Hz, done by a 32-bit phase accumulator.
  localparam logic [63:0] CLK_HZ = 64'd200_000_000;
  localparam logic [63:0] FREQ_DIV_MILLISEC = 64'd128;
  localparam logic [31:0] TONE_INC_K =
    32'((64'h1_0000_0000 * 64'd1000) / (FREQ_DIV_MILLISEC * CLK_HZ));

  // PCM slot geometry and the data FIFO shape.
  localparam int SLOT_BITS = 8;
  localparam logic [5:0] BIT_CNT_MAX = 6'h3F;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;

endpackage

// File: include/vfc_stream_if.sv
// Valid/ready carrier between the control block and its data FIFO.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface vfc_stream_if #(
  parameter int WIDTH = 8
);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;

  modport fifo (input in_valid, input in_data, output in_ready,
                output out_valid, output out_data, input out_ready);
  modport user (output in_valid, output in_data, input in_ready,
                input out_valid, input out_data, output out_ready);
endinterface

// File: tb/vfc_control_properties.sv
// Port-level assertions for the voice front end control block.
// Assumes the vfc_control port list; attached by the bind at the foot.
`timescale 1ns/1ps
module vfc_control_properties (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic bclk_i,
  input wire logic co_oe_n_o,
  input wire logic dx_o,
  input wire logic dx_oe_n_o,
  input wire logic [7:0] rx_dec_data_o,
  input wire logic rx_dec_valid_o,
  input wire logic rx_dec_ready_i,
  input wire logic tx_input_on_o,
  input wire logic sidetone_on_o,
  input wire logic [4:0] speaker_att_db_o,
  input wire logic [4:0] tone_a_att_db_o,
  input wire logic [4:0] tone_b_att_db_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////////////////
  // Legal routing and level codes, dx pins moving only just after a sampled high bit clock, decoder hold, co release.
  a_sidetone_gated: assert property (
    sidetone_on_o |-> tx_input_on_o) else $error("sidetone on with tx input off");
  a_speaker_even_step: assert property (
    speaker_att_db_o[0] == 1'b0 && speaker_att_db_o <= 5'h1E) else $error("bad speaker step");
  a_tone_b_offset: assert property (
    tone_a_att_db_o != 5'h00 |-> tone_b_att_db_o == 5'(tone_a_att_db_o + 5'h02))
    else $error("tone b level not 2 dB below a");
  a_tone_a_steps: assert property (
    tone_a_att_db_o <= 5'h1B && (tone_a_att_db_o >= 5'h18 || 5'(tone_a_att_db_o % 5'h03) == 5'h00))
    else $error("tone attenuation off its steps");
  a_dx_after_bclk: assert property (
    $changed(dx_o) |-> $past(bclk_i)) else $error("dx moved without bit clock");
  a_dx_oe_after_bclk: assert property (
    $changed(dx_oe_n_o) |-> $past(bclk_i)) else $error("dx enable moved without bit clock");
  a_dec_valid_hold: assert property (
    rx_dec_valid_o && !rx_dec_ready_i |=> rx_dec_valid_o && $stable(rx_dec_data_o))
    else $error("decoder byte dropped before ready");
  a_co_release: assert property (
    cs_n_i [*3] |-> co_oe_n_o) else $error("co driven while deselected");
endmodule // vfc_control_properties

bind vfc_control vfc_control_properties chk (.*);

// File: tb/vfc_control_tb.sv
// Self-checking bench for the voice front end control block.
// Assumes the host model for the control link; the bench plays the PCM link.
`timescale 1ns/1ps
module vfc_control_tb;
  logic clk_i = 1'b0, resetn_i = 1'b0, cs_n_i, cclk_i, ci_i, co_o, co_oe_n_o;
  logic gci_mode_i = 1'b0, fs_i = 1'b0, bclk_i = 1'b0, dr_i = 1'b0, dx_o, dx_oe_n_o;
  logic [7:0] tx_enc_data_i = 8'hC3, rx_dec_data_o, rd, dxb;
  logic rx_dec_valid_o, rx_dec_ready_i = 1'b0, rx_dec_drop_o, wave_shape_o;
  logic mic_choice_o, tx_input_on_o, sidetone_on_o, aux_to_speaker_amp_o, tonegen_to_tx_path_o;
  logic tonegen_to_loudspeaker_o, tonegen_to_earpiece_o, speech_to_loudspeaker_o;
  logic speech_to_earpiece_o;
  logic [3:0] tx_gain_db_o, sidetone_att_code_o, earpiece_att_db_o;
  logic [4:0] speaker_att_db_o, tone_a_att_db_o, tone_b_att_db_o;
  logic [1:0] tone_square_o;
  logic [15:0] tone_phase_o;
  int err_count = 0, checked = 0, cycles = 0, drops = 0, oe;
  vfc_control dut (.*);
  vfc_host_model host (.clk_i, .co_i(co_o), .co_oe_n_i(co_oe_n_o), .cs_n_o(cs_n_i),
    .cclk_o(cclk_i), .ci_o(ci_i));
  always #2.5 clk_i = ~clk_i;
  // The ceiling sits well above the roughly 13500 cycles the tests need.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (rx_dec_drop_o === 1'b1) drops++;
    if (cycles == 60000) begin
      err_count++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host.xfer({a, 4'h0, d}, rd);
  endtask
  task automatic rdr(input logic [3:0] a);
    host.xfer({a, 4'h4, 8'h00}, rd);
  endtask
  // One 32-bit frame; dr idles on a toggling pattern, bclk stops afterwards.
  task automatic frame(input int sl, input logic [7:0] drb);
    oe = 0;
    for (int b = 0; b < 32; b++) begin
      @(posedge clk_i);
      fs_i <= (b == 0);
      bclk_i <= 1'b1;
      dr_i <= (b >= sl && b < sl + 8) ? drb[7 - (b - sl)] : ~dr_i;
      repeat (4) @(posedge clk_i);
      bclk_i <= 1'b0;
      if (b >= sl && b < sl + 8) dxb[7 - (b - sl)] = dx_o;
      if (dx_oe_n_o === 1'b0) oe++;
      repeat (3) @(posedge clk_i);
    end
  endtask
  task automatic pop(input logic [7:0] exp);
    for (int i = 0; i < 20 && rx_dec_valid_o !== 1'b1; i++) @(posedge clk_i);
    chk({rx_dec_valid_o, rx_dec_data_o}, {1'b1, exp});
    rx_dec_ready_i <= 1'b1;
    @(posedge clk_i);
    rx_dec_ready_i <= 1'b0;
    @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int i = 1; i < 11; i++) begin
      rdr(4'(i));
      chk(rd, 8'h00);
      wr(4'(i), 8'(i * 17 + 128));
      rdr(4'(i));
      chk(rd, (i == 2 || i == 3 || i == 10) ? 8'h00 : 8'(i * 17 + 128));
    end
    $display("t_regs done");
  endtask
  task automatic t_route();
    wr(4, 8'hA5);
    chk({mic_choice_o, tx_input_on_o, sidetone_on_o, aux_to_speaker_amp_o, tonegen_to_loudspeaker_o,
      tonegen_to_earpiece_o, speech_to_loudspeaker_o, speech_to_earpiece_o}, 8'h85);
    wr(4, 8'h7A);
    chk({mic_choice_o, tx_input_on_o, sidetone_on_o, aux_to_speaker_amp_o, tonegen_to_loudspeaker_o,
      tonegen_to_earpiece_o, speech_to_loudspeaker_o, speech_to_earpiece_o}, 8'h7A);
    wr(5, 8'hF3);
    wr(6, 8'hAF);
    chk({tx_gain_db_o, sidetone_att_code_o}, 8'hF3);
    chk({earpiece_att_db_o, speaker_att_db_o}, {4'hA, 5'h1E});
    $display("t_route done");
  endtask
  task automatic t_tone();
    wr(7, 8'h00);
    chk(tone_phase_o, 16'h0000);
    chk(tone_square_o, 2'b00);
    wr(8, 8'h80);
    wr(9, 8'h40);
    wr(7, 8'h7E);
    chk({tone_a_att_db_o, tone_b_att_db_o, wave_shape_o, tonegen_to_tx_path_o}, 12'hADE);
    repeat (2000) @(posedge clk_i);
    chk(tone_phase_o, 16'h0102);
    wr(7, 8'h91);
    chk({tone_a_att_db_o, tone_b_att_db_o, wave_shape_o, tonegen_to_tx_path_o}, 12'hDF5);
    chk(tone_phase_o, 16'h0000);
    $display("t_tone done");
  endtask
  task automatic pcm(input logic g, input logic [7:0] cfg, input int sl, input logic [7:0] txe,
    input logic [7:0] dec);
    gci_mode_i <= g;
    wr(1, cfg);
    frame(sl, {cfg[3:0], 4'h5});
    chk(oe, cfg[2] ? 8 : 0);
    if (cfg[2]) chk(dxb, txe);
    if (cfg[2]) pop(dec);
    else chk(rx_dec_valid_o, 1'b0);
    rdr(2);
    chk(rd, {cfg[3:0], 4'h5});
  endtask
  task automatic t_pcm();
    wr(3, 8'hA6);
    pcm(1'b0, 8'h0D, 8, 8'hA6, 8'hD5);
    pcm(1'b1, 8'h0F, 24, 8'hA6, 8'hF5);
    pcm(1'b0, 8'h07, 8, 8'hC3, 8'h75);
    pcm(1'b0, 8'h0B, 8, 8'hA6, 8'hB5);
    wr(2, 8'h5A);
    pcm(1'b0, 8'h17, 8, 8'hC3, 8'h5A);
    wr(1, 8'h05);
    for (int k = 0; k < 18; k++) frame(8, 8'(k));
    chk(drops, 1);
    for (int k = 0; k < 17; k++) pop(8'(k));
    chk(rx_dec_valid_o, 1'b0);
    $display("t_pcm done");
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_regs();
    t_route();
    t_tone();
    t_pcm();
    tally_and_finish();
  end
endmodule // vfc_control_tb

// File: tb/vfc_host_model.sv
// Host controller model driving the two-byte serial control link.
// Assumes the block samples cs, cclk and ci on clk_i; cclk stands still when idle.
`timescale 1ns/1ps
module vfc_host_model (
  input wire logic clk_i,
  input wire logic co_i,
  input wire logic co_oe_n_i,
  output logic cs_n_o = 1'b1,
  output logic cclk_o = 1'b0,
  output logic ci_o = 1'b0
);
  // Msb first, three clocks per phase; an undriven co reads as wrong bits.
  task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (3) @(posedge clk_i);
      cclk_o <= 1'b0;
      ci_o <= w[i];
      repeat (3) @(posedge clk_i);
      cclk_o <= 1'b1;
      if (i < 8) rd[i] = co_oe_n_i ? ~co_i : co_i;
    end
    repeat (3) @(posedge clk_i);
    cclk_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    cs_n_o <= 1'b1;
    ci_o <= ~ci_o;
    repeat (3) @(posedge clk_i);
  endtask
endmodule // vfc_host_model
